// ==== hdl/aux_converter_trigger_sequencer.sv ====
// trigger scheduling and input sequencing for the auxiliary converter
// assumes the register port, gate pin and converter handshake are synchronous to core_clk_i
// Operation
// R1: eight converter inputs, each independently included or excluded by software.
// R2: each accepted trigger converts every included input once; excluded inputs skipped.
// R3: include bits 0..7 map to ext one..four, usb, line, battery, temperature; reset 0.
// R4: software includes at least one input before starting a set.
// R5: schedule select bit 14: 0 polled, 1 periodic; resets to polled.
// R6: writing 1 to poll bit 13 starts one set; hardware clears it afterwards.
// R7: poll bit only starts a set in polled operation.
// R8: after a polled set the block idles until the next trigger.
// R9: periodic rate bits 10:8 select 1, 4, 8 .. 256 Hz.
// R10: gate behaviour bits 13:12 reset 00 ignore the pin; 10 is reserved.
// R11: gate behaviour 01 suppresses polled and periodic triggers while gate asserted.
// R12: gate behaviour 11 lets only the gate pin start sets.
// R13: pin mode starts a set on rising edge if polarity 1, falling if 0.
// R14: the gate driver holds the pin asserted until the set completes.
// R15: software leaves include bits alone until earlier results are read.
// R16: triggers arriving during a set are dropped, never queued.
// R17: converter enable lives at bit 7 and bit 15 of two addresses, one flop.
// R18: new result flag sets on fresh data, clears when status register read.
// R19: with hold until read and unread results, any trigger is discarded.
`default_nettype none
module aux_converter_trigger_sequencer #(
	parameter int CLK_FREQ_HZ = aux_trig_pkg::CLK_HZ
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire aux_trig_pkg::reg_req_t reg_req_i,
	output logic [15:0] reg_rdata_o,
	input wire logic gate_pin_i,
	input wire logic pin_polarity_setting_i,
	input wire logic results_unread_i,
	output aux_trig_pkg::conv_req_t conv_o,
	input wire logic conv_done_i,
	output logic busy_o,
	output logic new_result_flag_o
);
	import aux_trig_pkg::*;

	// ==========================================
	// registers
	logic [NUM_INPUTS-1:0] input_include_bits_reg;
	logic schedule_select_reg;
	logic one_shot_trigger_reg;
	logic converter_enable_reg;
	logic [2:0] periodic_rate_reg;
	logic [1:0] gate_behaviour_reg;
	logic hold_until_read_reg;
	logic new_result_flag_reg;
	logic [15:0] rdata_reg;
	logic gate_prev_reg;
	logic [TICK_W-1:0] tick_reg;
	seq_state_t state_reg;
	logic [2:0] chan_reg;
	logic [NUM_INPUTS-1:0] set_incl_reg;

	// ==========================================
	// decode
	wire wr_trig = reg_req_i.wr && (reg_req_i.addr == ADDR_TRIG_SEL);
	wire wr_gate = reg_req_i.wr && (reg_req_i.addr == ADDR_GATE_RATE);
	wire wr_pwr = reg_req_i.wr && (reg_req_i.addr == ADDR_POWER_MGMT);
	wire rd_status = reg_req_i.rd && (reg_req_i.addr == ADDR_IRQ_STATUS);
	wire idle = (state_reg == ST_IDLE);
	wire pin_mode = (gate_behaviour_reg == GATE_TRIGGER); // see R12
	wire gate_asserted = gate_pin_i ~^ pin_polarity_setting_i;
	wire gate_edge = gate_asserted && !gate_prev_reg; // see R13
	wire inhibited = (gate_behaviour_reg == GATE_INHIBIT) && gate_asserted; // see R11
	wire held = hold_until_read_reg && results_unread_i; // see R19
	wire periodic_on = converter_enable_reg && schedule_select_reg && !pin_mode; // see R5
	wire polled_mode = !schedule_select_reg && !pin_mode; // see R7
	wire last_chan = (chan_reg == 3'(NUM_INPUTS - 1));

	// periodic interval: 000 is 1 Hz, code n above it is 2^(n+1) Hz
	wire [4:0] rate_shift = (periodic_rate_reg == RATE_RESET) ? 5'h0 : 5'({2'b00, periodic_rate_reg} + 5'h1); // see R9
	wire [TICK_W-1:0] period_cycles = TICK_W'(CLK_FREQ_HZ / SLOWEST_RATE_HZ) >> rate_shift;
	wire period_tick = periodic_on && (tick_reg >= period_cycles - TICK_W'(1));

	// candidate triggers from each source
	wire poll_trig = polled_mode && one_shot_trigger_reg && !inhibited; // see R6
	wire rate_trig = period_tick && !inhibited;
	wire pin_trig = pin_mode && gate_edge && converter_enable_reg;
	wire any_trig = converter_enable_reg && (poll_trig || rate_trig || pin_trig);
	wire start_set = any_trig && idle && !held; // see R16
	wire discard = any_trig && idle && held; // see R19

	wire set_done = ((state_reg == ST_SCAN) && !set_incl_reg[chan_reg] && last_chan) ||
		((state_reg == ST_CONV) && conv_done_i && last_chan);

	// ==========================================
	// software-visible control
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			input_include_bits_reg <= INCL_RESET; // see R3
			schedule_select_reg <= 1'b0; // see R5
			converter_enable_reg <= 1'b0;
			periodic_rate_reg <= RATE_RESET;
			gate_behaviour_reg <= GATE_IGNORE; // see R10
			hold_until_read_reg <= 1'b0;
		end else begin
			if (wr_trig) begin
				input_include_bits_reg <= reg_req_i.wdata[INCL_LSB +: NUM_INPUTS]; // see R1
				schedule_select_reg <= reg_req_i.wdata[SCHED_BIT];
			end
			if (wr_trig) begin
				converter_enable_reg <= reg_req_i.wdata[ENA_BIT]; // see R17
			end else if (wr_pwr) begin
				converter_enable_reg <= reg_req_i.wdata[ENA_ALIAS_BIT]; // see R17
			end
			if (wr_gate) begin
				periodic_rate_reg <= reg_req_i.wdata[RATE_LSB +: 3];
				gate_behaviour_reg <= reg_req_i.wdata[GATE_LSB +: 2];
				hold_until_read_reg <= reg_req_i.wdata[HOLD_BIT];
			end
		end
	end

	// poll bit: accepted only when polled and idle; cleared by completion, discard or leaving polled operation
	wire poll_accept = wr_trig && reg_req_i.wdata[POLL_BIT] && !reg_req_i.wdata[SCHED_BIT] && !pin_mode && idle;
	wire poll_clear = set_done || (discard && poll_trig) || pin_mode || schedule_select_reg;
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			one_shot_trigger_reg <= 1'b0;
		else if (poll_accept) // see R7
			one_shot_trigger_reg <= 1'b1;
		else if (poll_clear) // see R6
			one_shot_trigger_reg <= 1'b0;
	end

	// fresh data sets the flag; a read in the same cycle does not lose it
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			new_result_flag_reg <= 1'b0;
		else if ((state_reg == ST_CONV) && conv_done_i) // see R18
			new_result_flag_reg <= 1'b1;
		else if (rd_status) // see R18
			new_result_flag_reg <= 1'b0;
	end

	// ==========================================
	// read data
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = RDATA_ZERO;
		case (reg_req_i.addr)
			ADDR_TRIG_SEL: begin
				rd_mux[INCL_LSB +: NUM_INPUTS] = input_include_bits_reg;
				rd_mux[POLL_BIT] = one_shot_trigger_reg;
				rd_mux[SCHED_BIT] = schedule_select_reg;
				rd_mux[ENA_BIT] = converter_enable_reg;
			end
			ADDR_GATE_RATE: begin
				rd_mux[RATE_LSB +: 3] = periodic_rate_reg;
				rd_mux[GATE_LSB +: 2] = gate_behaviour_reg;
				rd_mux[HOLD_BIT] = hold_until_read_reg;
			end
			ADDR_POWER_MGMT: rd_mux[ENA_ALIAS_BIT] = converter_enable_reg;
			ADDR_IRQ_STATUS: rd_mux[NEW_RESULT_BIT] = new_result_flag_reg;
			default: rd_mux = RDATA_ZERO;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			rdata_reg <= RDATA_ZERO;
		else if (reg_req_i.rd)
			rdata_reg <= rd_mux;
	end

	// ==========================================
	// gate edge and periodic timer
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gate_prev_reg <= 1'b0;
			tick_reg <= '0;
		end else begin
			gate_prev_reg <= gate_asserted;
			// the timer free-runs so a dropped tick never shifts the cadence
			if (!periodic_on || period_tick)
				tick_reg <= '0;
			else
				tick_reg <= tick_reg + TICK_W'(1);
		end
	end

	// ==========================================
	// set sequencer: steps every input, one cycle per excluded one
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= ST_IDLE;
			chan_reg <= 3'h0;
			set_incl_reg <= INCL_RESET;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start_set) begin
						// include bits are frozen for the whole set
						set_incl_reg <= input_include_bits_reg; // see R2
						chan_reg <= 3'h0;
						state_reg <= ST_SCAN;
					end
				end
				ST_SCAN: begin
					if (set_incl_reg[chan_reg])
						state_reg <= ST_CONV; // see R2
					else if (last_chan)
						state_reg <= ST_IDLE; // see R8
					else
						chan_reg <= chan_reg + 3'h1;
				end
				ST_CONV: begin
					if (conv_done_i) begin
						if (last_chan) begin
							state_reg <= ST_IDLE; // see R8
						end else begin
							chan_reg <= chan_reg + 3'h1;
							state_reg <= ST_SCAN;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// one driver for the whole carrier keeps the output a single-source variable
	assign conv_o = '{req: (state_reg == ST_CONV), chan: chan_reg};
	assign busy_o = !idle;
	assign new_result_flag_o = new_result_flag_reg;
	assign reg_rdata_o = rdata_reg;
endmodule
`default_nettype wire

// ==== hdl/aux_trig_pkg.sv ====
// constants, register map and carrier types for the converter trigger sequencer
// assumes one 125 MHz clock and the device's own register port
`default_nettype none
package aux_trig_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] ADDR_POWER_MGMT = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1A;
	localparam logic [7:0] ADDR_TRIG_SEL = 8'h90;
	localparam logic [7:0] ADDR_GATE_RATE = 8'h91;

	// ==========================================
	// field positions
	localparam int ENA_ALIAS_BIT = 7;
	localparam int ENA_BIT = 15;
	localparam int SCHED_BIT = 14;
	localparam int POLL_BIT = 13;
	localparam int INCL_LSB = 0;
	localparam int NUM_INPUTS = 8;
	localparam int RATE_LSB = 8;
	localparam int GATE_LSB = 12;
	localparam int HOLD_BIT = 15;
	localparam int NEW_RESULT_BIT = 0;

	// ==========================================
	// reset values and encodings
	localparam logic [7:0] INCL_RESET = 8'h00;
	localparam logic [2:0] RATE_RESET = 3'h0;
	localparam logic [1:0] GATE_IGNORE = 2'h0;
	localparam logic [1:0] GATE_INHIBIT = 2'h1;
	localparam logic [1:0] GATE_TRIGGER = 2'h3;
	localparam logic [15:0] RDATA_ZERO = 16'h0000;

	// ==========================================
	// timing
	localparam int CLK_HZ = 125_000_000;
	localparam int SLOWEST_RATE_HZ = 1;
	localparam int TICK_W = 32;

	typedef enum {ST_IDLE, ST_SCAN, ST_CONV} seq_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic req;
		logic [2:0] chan;
	} conv_req_t;
endpackage
`default_nettype wire

// ==== testbench/aux_trig_props.sv ====
// port assertions for the trigger sequencer
// assumes it is bound onto the sequencer top
`default_nettype none
module aux_trig_props #(
	parameter int CLK_FREQ_HZ = aux_trig_pkg::CLK_HZ
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire aux_trig_pkg::reg_req_t reg_req_i,
	input wire logic [15:0] reg_rdata_o,
	input wire aux_trig_pkg::conv_req_t conv_o,
	input wire logic conv_done_i,
	input wire logic busy_o,
	input wire logic new_result_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import aux_trig_pkg::*;
	logic fin;
	assign fin = conv_o.req && conv_done_i;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// the bus tasks leave one idle cycle between a write and the next read
	sequence wr_rd(wa, ra);
		reg_req_i.wr && reg_req_i.addr == wa ##2 reg_req_i.rd && reg_req_i.addr == ra;
	endsequence
	// ==========
	// handshake, flag, readback and aliases
	a_req_holds: assert property (conv_o.req && !conv_done_i |=> conv_o.req && $stable(conv_o.chan))
		else $error("request dropped");
	a_req_in_set: assert property (conv_o.req |-> busy_o)
		else $error("request outside set");
	a_req_once: assert property (fin |=> !conv_o.req)
		else $error("input repeated");
	a_flag_sets: assert property (fin |=> new_result_flag_o)
		else $error("flag not set");
	a_flag_clears: assert property (reg_req_i.rd && reg_req_i.addr == ADDR_IRQ_STATUS && !conv_done_i
		|=> !new_result_flag_o)
		else $error("flag not cleared");
	a_trig_readback: assert property (wr_rd(ADDR_TRIG_SEL, ADDR_TRIG_SEL)
		|=> (reg_rdata_o & 16'h40FF) == ($past(reg_req_i.wdata, 3) & 16'h40FF))
		else $error("select readback");
	a_enable_alias: assert property (wr_rd(ADDR_POWER_MGMT, ADDR_TRIG_SEL)
		|=> reg_rdata_o[15] == $past(reg_req_i.wdata[7], 3))
		else $error("enable alias");
	a_alias_back: assert property (wr_rd(ADDR_TRIG_SEL, ADDR_POWER_MGMT)
		|=> reg_rdata_o[7] == $past(reg_req_i.wdata[15], 3))
		else $error("enable alias back");
	c_conv: cover property (fin);
	c_set: cover property ($rose(busy_o));
	c_flag_read: cover property (reg_req_i.rd && reg_req_i.addr == ADDR_IRQ_STATUS && new_result_flag_o);
endmodule
bind aux_converter_trigger_sequencer aux_trig_props #(.CLK_FREQ_HZ(CLK_FREQ_HZ)) aux_trig_props_i (
	.core_clk_i(core_clk_i),
	.arst_n_i(arst_n_i),
	.reg_req_i(reg_req_i),
	.reg_rdata_o(reg_rdata_o),
	.conv_o(conv_o),
	.conv_done_i(conv_done_i),
	.busy_o(busy_o),
	.new_result_flag_o(new_result_flag_o)
);
`default_nettype wire

// ==== testbench/conv_model.sv ====
// behavioural converter answering each request after a short or long wait
// assumes a request stands until its done pulse
`default_nettype none
module conv_model (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire aux_trig_pkg::conv_req_t conv_i,
	input wire logic slow_i,
	output logic done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import aux_trig_pkg::*;
	logic [3:0] n;
	// ==========
	// one done pulse per request
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			n <= 4'h0;
			done_o <= 1'b0;
		end else begin
			done_o <= conv_i.req && !done_o && n == (slow_i ? 4'h9 : 4'h2);
			n <= conv_i.req && !done_o ? n + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// bench: register rows, then poll, periodic, gate, pin and hold cases
// assumes the design package and conv_model
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import aux_trig_pkg::*;
	localparam int F = 1024;
	typedef struct {logic [7:0] wa; logic [15:0] wd; logic [7:0] ra; logic [15:0] ex;} row_t;
	row_t rows[4] = '{'{ADDR_TRIG_SEL, 16'h40A5, ADDR_TRIG_SEL, 16'h40A5},
		'{ADDR_POWER_MGMT, 16'h0080, ADDR_TRIG_SEL, 16'hC0A5}, '{ADDR_TRIG_SEL, 16'h00FF, ADDR_POWER_MGMT, 16'h0000},
		'{ADDR_GATE_RATE, 16'hB700, ADDR_GATE_RATE, 16'hB700}};
	logic clk = 1'b0, rst_n = 1'b0, gate = 1'b0, pol = 1'b1, unread = 1'b0, slow = 1'b0, bd = 1'b0, busy, done, flag;
	logic [15:0] rdata;
	logic [2:0] ch[$];
	reg_req_t req = '0;
	conv_req_t conv;
	int bad_count = 0, num_checks = 0, sets = 0, cyc = 0, rise = 0, period = 0, s0, p;
	always #4 clk = ~clk;
	aux_converter_trigger_sequencer #(.CLK_FREQ_HZ(F)) aux_converter_trigger_sequencer_i (.core_clk_i(clk),
		.arst_n_i(rst_n), .reg_req_i(req), .reg_rdata_o(rdata), .gate_pin_i(gate), .pin_polarity_setting_i(pol),
		.results_unread_i(unread), .conv_o(conv), .conv_done_i(done), .busy_o(busy), .new_result_flag_o(flag));
	conv_model conv_model_i (.core_clk_i(clk), .arst_n_i(rst_n), .conv_i(conv), .slow_i(slow), .done_o(done));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		bd <= busy;
		if (busy && !bd) begin
			sets <= sets + 1;
			period <= cyc - rise;
			rise <= cyc;
		end
		if (conv.req && done)
			ch.push_back(conv.chan);
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk) req <= '{1'b1, 1'b0, a, d};
		@(posedge clk) req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk) req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk) req.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic wait_sets(input int n);
		for (int i = 0; i < 3000 && (sets < n || busy); i++)
			@(posedge clk);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		$display("unexpected at %0t: timeout", $time);
		results;
	end
	// ==========
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_TRIG_SEL, 16'h0000);
		rd(ADDR_GATE_RATE, 16'h0000);
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rd(rows[i].ra, rows[i].ex);
		end
		wr(ADDR_GATE_RATE, 16'h0000);
		ch.delete();
		s0 = sets;
		wr(ADDR_TRIG_SEL, 16'hA005);
		wr(ADDR_TRIG_SEL, 16'hA005);
		wait_sets(s0 + 1);
		repeat (20) @(posedge clk);
		chk(16'(sets - s0), 16'h0001);
		chk(16'({ch.size(), ch[0], ch[1]}), 16'h0082);
		rd(ADDR_TRIG_SEL, 16'h8005);
		chk(16'(flag), 16'h0001);
		rd(ADDR_IRQ_STATUS, 16'h0001);
		chk(16'(flag), 16'h0000);
		rd(ADDR_IRQ_STATUS, 16'h0000);
		wr(ADDR_TRIG_SEL, 16'hC005);
		// fast codes outrun a slow set, so the interval must be a whole number of ticks
		for (int k = 7; k >= 0; k--) begin
			p = k == 0 ? F : F >> (k + 1);
			slow <= k > 4;
			wr(ADDR_GATE_RATE, 16'(k << 8));
			s0 = sets;
			wait_sets(s0 + 2);
			chk(16'(k > 4 ? period % p : period), 16'(k > 4 ? 0 : p));
		end
		s0 = sets;
		wr(ADDR_TRIG_SEL, 16'hE005);
		repeat (50) @(posedge clk);
		chk(16'(sets - s0), 16'h0000);
		@(posedge clk) gate <= 1'b1;
		wr(ADDR_GATE_RATE, 16'h1400);
		s0 = sets;
		repeat (100) @(posedge clk);
		chk(16'(sets - s0), 16'h0000);
		@(posedge clk) gate <= 1'b0;
		wait_sets(s0 + 1);
		chk(16'(sets > s0), 16'h0001);
		wr(ADDR_GATE_RATE, 16'h3400);
		for (int q = 1; q >= 0; q--) begin
			@(posedge clk) pol <= q[0];
			gate <= !q[0];
			s0 = sets;
			wr(ADDR_TRIG_SEL, q ? 16'hE005 : 16'hA005);
			repeat (40) @(posedge clk);
			@(posedge clk) gate <= q[0];
			wait_sets(s0 + 1);
			chk(16'(sets - s0), 16'h0001);
		end
		@(posedge clk) unread <= 1'b1;
		wr(ADDR_GATE_RATE, 16'h8000);
		s0 = sets;
		wr(ADDR_TRIG_SEL, 16'hA005);
		repeat (30) @(posedge clk);
		chk(16'(sets - s0), 16'h0000);
		rd(ADDR_TRIG_SEL, 16'h8005);
		// a pending poll waits out the inhibit and starts once the gate lets go
		@(posedge clk) unread <= 1'b0;
		wr(ADDR_GATE_RATE, 16'h1000);
		s0 = sets;
		wr(ADDR_TRIG_SEL, 16'hA005);
		repeat (30) @(posedge clk);
		chk(16'(sets - s0), 16'h0000);
		@(posedge clk) gate <= 1'b1;
		wait_sets(s0 + 1);
		chk(16'(sets - s0), 16'h0001);
		// a reset in mid-set drops the request at once and clears every field
		wr(ADDR_TRIG_SEL, 16'hA005);
		repeat (4) @(posedge clk);
		chk(16'(busy), 16'h0001);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk(16'({busy, conv.req, flag}), 16'h0000);
		rst_n <= 1'b1;
		rd(ADDR_TRIG_SEL, 16'h0000);
		rd(ADDR_GATE_RATE, 16'h0000);
		results;
	end
endmodule
`default_nettype wire
